// ### rtl/plrh_params.svh
// constants of the link request handler: offsets, fields, reset values
`ifndef PLRH_PARAMS_SVH
`define PLRH_PARAMS_SVH

// request stream layout (bit counts index from the start bit)
`define PLRH_CNT_W 5
`define PLRH_SR_W 16
`define PLRH_IDX_TYPE 5'd4
`define PLRH_IDX_ACCEL 5'd5
`define PLRH_IDX_BUS_SHORT 5'd6
`define PLRH_IDX_BUS_LONG 5'd7
`define PLRH_IDX_READ 5'd8
`define PLRH_IDX_WRITE 5'd16

// valid bus request speed codes
`define PLRH_SPD_S100 3'h0
`define PLRH_SPD_S200 3'h2
`define PLRH_SPD_S400 3'h4

// device-driven control pair codes
`define PLRH_CTL_IDLE 2'h0
`define PLRH_CTL_STATUS 2'h1
`define PLRH_CTL_RECEIVE 2'h2
`define PLRH_CTL_GRANT 2'h3

// device register holding the acceleration enable bit
`define PLRH_EAA_ADDR 4'h5
`define PLRH_EAA_BIT 1

// bus register map (byte addresses)
`define PLRH_WB_ADR_W 8
`define PLRH_OFF_STATUS 8'h00
`define PLRH_OFF_CTRL 8'h04
`define PLRH_OFF_REGS 8'h40
`define PLRH_REGS_MASK 8'hC3
`define PLRH_CTRL_RST 1'b1
`define PLRH_ACCEL_RST 1'b1
`define PLRH_EAA_RST 1'b0
`define PLRH_REG_RST 8'h00

`endif

// ### rtl/plrh_pkg.sv
// types shared by the link request handler
package plrh_pkg;

    // request type field, bits 1 to 3 of every request
    typedef enum logic [2:0] {
        PLRH_REQ_IMM = 3'b000,
        PLRH_REQ_ISO = 3'b001,
        PLRH_REQ_PRI = 3'b010,
        PLRH_REQ_FAIR = 3'b011,
        PLRH_REQ_READ = 3'b100,
        PLRH_REQ_WRITE = 3'b101,
        PLRH_REQ_ACCEL = 3'b110,
        PLRH_REQ_RSVD = 3'b111
    } plrh_req_t;

    // serial receiver state
    typedef enum logic {
        PLRH_ST_IDLE = 1'b0,
        PLRH_ST_SHIFT = 1'b1
    } plrh_state_t;

endpackage : plrh_pkg

// ### rtl/plrh_regfile.sv
// sixteen 8-bit device registers, two write ports, two registered reads
`timescale 1ns/100ps
`include "plrh_params.svh"

module plrh_regfile
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wa_en_i,
    input wire logic [3:0] wa_addr_i,
    input wire logic [7:0] wa_data_i,
    input wire logic wb_en_i,
    input wire logic [3:0] wb_addr_i,
    input wire logic [7:0] wb_data_i,
    input wire logic [3:0] ra_addr_i,
    output logic [7:0] ra_data_o,
    input wire logic [3:0] rb_addr_i,
    output logic [7:0] rb_data_o
);

    logic [7:0] mem_reg [0:15];

    // =====================================================================
    // storage: port a wins when both ports hit one address
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < 16; i++)
            begin
                mem_reg[i] <= `PLRH_REG_RST;
            end
        end
        else
        begin
            if (wb_en_i && !(wa_en_i && wa_addr_i == wb_addr_i))
            begin
                mem_reg[wb_addr_i] <= wb_data_i;
            end
            if (wa_en_i)
            begin
                mem_reg[wa_addr_i] <= wa_data_i;
            end
        end
    end

    // =====================================================================
    // registered read ports, one cycle after the address
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ra_data_o <= `PLRH_REG_RST;
            rb_data_o <= `PLRH_REG_RST;
        end
        else
        begin
            ra_data_o <= mem_reg[ra_addr_i];
            rb_data_o <= mem_reg[rb_addr_i];
        end
    end

endmodule : plrh_regfile

// ### rtl/plrh_top.sv
// link request handler: serial request decode, bus request and register ops
`timescale 1ns/100ps
`include "plrh_params.svh"

module plrh_top
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic LINK_REQUEST_LINE_I,
    input wire logic [1:0] INTERFACE_CONTROL_PAIR_I,
    input wire logic BUS_RESET_I,
    input wire logic ARB_WON_I,
    input wire logic STATUS_DONE_I,
    output logic IMMEDIATE_BUS_REQ_O,
    output logic ISOCHRONOUS_BUS_REQ_O,
    output logic PRIORITY_BUS_REQ_O,
    output logic FAIR_BUS_REQ_O,
    output logic [2:0] REQ_SPEED_O,
    output logic GRANT_O,
    output logic TX_NULL_O,
    output logic STATUS_REG_REQ_O,
    output logic [3:0] STATUS_ADDR_O,
    output logic [7:0] STATUS_DATA_O,
    output logic ACCEL_ACTIVE_O,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);

    // =====================================================================
    // helpers

    // speed code check for bus requests
    function automatic logic speed_ok(input logic [2:0] s);
        speed_ok = (s == `PLRH_SPD_S100) || (s == `PLRH_SPD_S200) ||
                   (s == `PLRH_SPD_S400);
    endfunction : speed_ok

    // true for the four bus request kinds (msb of type clear)
    function automatic logic is_bus(input logic [2:0] t);
        is_bus = !t[2];
    endfunction : is_bus

    // =====================================================================
    // state
    plrh_pkg::plrh_state_t st_reg, st_next;
    logic [`PLRH_CNT_W-1:0] cnt_reg;
    logic [`PLRH_SR_W-1:0] sr_reg;
    logic [2:0] type_reg;
    logic rx_seen_reg;
    logic pend_reg;
    logic [2:0] kind_reg;
    logic [2:0] speed_reg;
    logic grant_reg;
    logic tx_null_reg;
    logic [1:0] ctl_prev_reg;
    logic rd_pend_reg;
    logic rd_ready_reg;
    logic [3:0] rd_addr_reg;
    logic accel_ctl_reg;
    logic eaa_reg;
    logic listen_reg;
    logic wb_stage_reg;
    logic ack_reg;
    logic [31:0] dat_reg;

    // =====================================================================
    // serial decode of the request line
    logic bit_in;
    logic [2:0] cur_type;
    logic type_known;
    logic bus_short;
    logic done;
    logic abort;
    logic stop_ok;
    logic [2:0] req_speed;
    logic rx_now;
    logic shifting;

    assign bit_in = LINK_REQUEST_LINE_I;
    assign shifting = (st_reg == plrh_pkg::PLRH_ST_SHIFT);
    assign type_known = shifting && (cnt_reg >= `PLRH_IDX_TYPE);
    // type is in sr[2:0] when bit 4 is on the line, latched afterwards
    assign cur_type = (cnt_reg == `PLRH_IDX_TYPE) ? sr_reg[2:0] : type_reg;
    assign rx_now = (INTERFACE_CONTROL_PAIR_I == `PLRH_CTL_RECEIVE);
    // a bus request with bit 6 low ends there; no stop bit is waited for
    assign bus_short = is_bus(cur_type) &&
                       cnt_reg == `PLRH_IDX_BUS_SHORT && !bit_in;

    // end of request by type: lengths 6, 7/8, 9 and 17 bits
    assign done = type_known && (
        (is_bus(cur_type) &&
            (bus_short || cnt_reg == `PLRH_IDX_BUS_LONG)) ||
        (cur_type == plrh_pkg::PLRH_REQ_READ &&
            cnt_reg == `PLRH_IDX_READ) ||
        (cur_type == plrh_pkg::PLRH_REQ_WRITE &&
            cnt_reg == `PLRH_IDX_WRITE) ||
        (cur_type == plrh_pkg::PLRH_REQ_ACCEL &&
            cnt_reg == `PLRH_IDX_ACCEL));
    // reserved type is dropped once its code is known
    assign abort = type_known && cur_type == plrh_pkg::PLRH_REQ_RSVD;
    // stop bit must be 0 unless omitted; a malformed request is dropped
    assign stop_ok = bus_short || !bit_in;
    assign req_speed = bus_short ? {sr_reg[1:0], bit_in} : sr_reg[2:0];

    // shifter next state
    always_comb
    begin
        st_next = st_reg;
        case (st_reg)
            plrh_pkg::PLRH_ST_IDLE:
            begin
                if (bit_in && listen_reg)
                begin
                    st_next = plrh_pkg::PLRH_ST_SHIFT;
                end
            end
            plrh_pkg::PLRH_ST_SHIFT:
            begin
                if (done || abort)
                begin
                    st_next = plrh_pkg::PLRH_ST_IDLE;
                end
            end
            default:
            begin
                st_next = plrh_pkg::PLRH_ST_IDLE;
            end
        endcase
    end

    // shift register, bit counter and type latch, msb first
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            st_reg <= plrh_pkg::PLRH_ST_IDLE;
            cnt_reg <= '0;
            sr_reg <= '0;
            type_reg <= 3'h0;
            rx_seen_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            if (!shifting)
            begin
                cnt_reg <= `PLRH_CNT_W'(1);
                sr_reg <= `PLRH_SR_W'(1);
                rx_seen_reg <= rx_now;
            end
            else
            begin
                cnt_reg <= cnt_reg + `PLRH_CNT_W'(1);
                sr_reg <= {sr_reg[`PLRH_SR_W-2:0], bit_in};
                rx_seen_reg <= rx_seen_reg | rx_now;
            end
            if (type_known)
            begin
                type_reg <= cur_type;
            end
        end
    end

    // =====================================================================
    // decoded request strobes
    logic req_ok;
    logic bus_fp;
    logic bus_take;
    logic rd_take;
    logic wr_take;
    logic acc_take;
    logic iso_take;

    assign req_ok = shifting && done && stop_ok;
    assign bus_fp = cur_type == plrh_pkg::PLRH_REQ_PRI ||
                    cur_type == plrh_pkg::PLRH_REQ_FAIR;
    // fair/priority seeing receive while shifted in are lost
    assign bus_take = req_ok && is_bus(cur_type) && !pend_reg &&
                      !(bus_fp && (rx_seen_reg || rx_now));
    assign iso_take = bus_take && cur_type == plrh_pkg::PLRH_REQ_ISO;
    // register requests do not look at the bus request state
    assign rd_take = req_ok && cur_type == plrh_pkg::PLRH_REQ_READ;
    assign wr_take = req_ok && cur_type == plrh_pkg::PLRH_REQ_WRITE;
    assign acc_take = req_ok && cur_type == plrh_pkg::PLRH_REQ_ACCEL;

    // =====================================================================
    // pending bus request and its resolution
    logic is_imm;
    logic rx_end;
    logic imm_grant;
    logic won_grant;
    logic grant_now;
    logic fp_lost;

    assign is_imm = kind_reg == plrh_pkg::PLRH_REQ_IMM;
    assign rx_end = (ctl_prev_reg == `PLRH_CTL_RECEIVE) && !rx_now;
    // immediate requests skip arbitration at the end of the packet
    assign imm_grant = pend_reg && is_imm && rx_end;
    assign won_grant = pend_reg && !is_imm && ARB_WON_I;
    assign grant_now = (imm_grant || won_grant) && !BUS_RESET_I;
    assign fp_lost = pend_reg && rx_now &&
                     (kind_reg == plrh_pkg::PLRH_REQ_PRI ||
                      kind_reg == plrh_pkg::PLRH_REQ_FAIR);

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            pend_reg <= 1'b0;
            kind_reg <= 3'h0;
            speed_reg <= 3'h0;
            grant_reg <= 1'b0;
            tx_null_reg <= 1'b0;
            ctl_prev_reg <= `PLRH_CTL_IDLE;
        end
        else
        begin
            ctl_prev_reg <= INTERFACE_CONTROL_PAIR_I;
            grant_reg <= grant_now;
            if (BUS_RESET_I)
            begin
                pend_reg <= 1'b0;
                tx_null_reg <= 1'b0;
            end
            else if (bus_take)
            begin
                pend_reg <= 1'b1;
                kind_reg <= cur_type;
                speed_reg <= req_speed;
            end
            else if (grant_now || fp_lost)
            begin
                pend_reg <= 1'b0;
            end
            if (grant_now)
            begin
                tx_null_reg <= !speed_ok(speed_reg);
            end
        end
    end

    assign IMMEDIATE_BUS_REQ_O = pend_reg && is_imm;
    assign ISOCHRONOUS_BUS_REQ_O = pend_reg &&
                                   kind_reg == plrh_pkg::PLRH_REQ_ISO;
    assign PRIORITY_BUS_REQ_O = pend_reg &&
                                kind_reg == plrh_pkg::PLRH_REQ_PRI;
    assign FAIR_BUS_REQ_O = pend_reg && kind_reg == plrh_pkg::PLRH_REQ_FAIR;
    assign REQ_SPEED_O = speed_reg;
    assign GRANT_O = grant_reg;
    assign TX_NULL_O = tx_null_reg;

    // =====================================================================
    // outstanding register read, held until the status transfer completes
    logic rd_load;
    logic [7:0] ra_data;

    // a read arriving as the previous one completes is kept, not lost
    assign rd_load = rd_take && (!rd_pend_reg || STATUS_DONE_I);

    // bus reset deliberately not in this process
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rd_pend_reg <= 1'b0;
            rd_ready_reg <= 1'b0;
            rd_addr_reg <= 4'h0;
        end
        else
        begin
            rd_ready_reg <= rd_pend_reg && !rd_load;
            if (rd_load)
            begin
                rd_pend_reg <= 1'b1;
                rd_addr_reg <= sr_reg[3:0];
            end
            else if (STATUS_DONE_I)
            begin
                rd_pend_reg <= 1'b0;
            end
        end
    end

    // request stays up across interrupted transfers until done comes
    assign STATUS_REG_REQ_O = rd_pend_reg && rd_ready_reg;
    assign STATUS_ADDR_O = rd_addr_reg;
    assign STATUS_DATA_O = ra_data;

    // =====================================================================
    // acceleration control
    logic link_eaa_wr;
    logic wb_wr;
    logic wb_reg_hit;
    logic [3:0] wb_idx;

    assign link_eaa_wr = wr_take && sr_reg[11:8] == `PLRH_EAA_ADDR;

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            accel_ctl_reg <= `PLRH_ACCEL_RST;
            eaa_reg <= `PLRH_EAA_RST;
        end
        else
        begin
            // a control request wins over a same-cycle re-enable
            if (acc_take)
            begin
                accel_ctl_reg <= sr_reg[0];
            end
            else if (BUS_RESET_I || iso_take)
            begin
                accel_ctl_reg <= 1'b1;
            end
            // shadow of register 5 enable bit, link write has priority
            if (link_eaa_wr)
            begin
                eaa_reg <= sr_reg[`PLRH_EAA_BIT];
            end
            else if (wb_wr && wb_reg_hit && wb_idx == `PLRH_EAA_ADDR)
            begin
                eaa_reg <= WB_DAT_I[`PLRH_EAA_BIT];
            end
        end
    end

    // register bit gates the control request state
    assign ACCEL_ACTIVE_O = eaa_reg && accel_ctl_reg;

    // =====================================================================
    // wishbone slave: ack two cycles after request, write at ack edge
    logic wb_req;
    logic [7:0] rb_data;
    logic [31:0] rd_mux;

    assign wb_req = WB_CYC_I && WB_STB_I;
    assign wb_idx = WB_ADR_I[5:2];
    assign wb_reg_hit = (WB_ADR_I & `PLRH_REGS_MASK) == `PLRH_OFF_REGS;
    assign wb_wr = wb_req && WB_WE_I && ack_reg && WB_SEL_I[0];
    assign rd_mux =
        (WB_ADR_I == `PLRH_OFF_STATUS) ?
            {20'h0, speed_reg, rd_pend_reg, ACCEL_ACTIVE_O, accel_ctl_reg,
             tx_null_reg, FAIR_BUS_REQ_O, PRIORITY_BUS_REQ_O,
             ISOCHRONOUS_BUS_REQ_O, IMMEDIATE_BUS_REQ_O, shifting} :
        (WB_ADR_I == `PLRH_OFF_CTRL) ? {31'h0, listen_reg} :
        wb_reg_hit ? {24'h0, rb_data} : 32'h0;

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            wb_stage_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            listen_reg <= `PLRH_CTRL_RST;
        end
        else
        begin
            wb_stage_reg <= wb_req && !wb_stage_reg && !ack_reg;
            ack_reg <= wb_req && wb_stage_reg;
            dat_reg <= (wb_req && wb_stage_reg) ? rd_mux : 32'h0000_0000;
            // listen off holds the serial receiver idle
            if (wb_wr && WB_ADR_I == `PLRH_OFF_CTRL)
            begin
                listen_reg <= WB_DAT_I[0];
            end
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;

    // =====================================================================
    // device registers: link write on port a, software on port b
    plrh_regfile u_regs
    (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .wa_en_i(wr_take),
        .wa_addr_i(sr_reg[11:8]),
        .wa_data_i(sr_reg[7:0]),
        .wb_en_i(wb_wr && wb_reg_hit),
        .wb_addr_i(wb_idx),
        .wb_data_i(WB_DAT_I[7:0]),
        .ra_addr_i(rd_addr_reg),
        .ra_data_o(ra_data),
        .rb_addr_i(wb_idx),
        .rb_data_o(rb_data)
    );

endmodule : plrh_top

// ### verif/plrh_link_model.sv
// link-side controller model: shifts request streams onto the line
`timescale 1ns/100ps

module plrh_link_model
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic go_i,
    input wire logic [4:0] len_i,
    input wire logic [16:0] bits_i,
    output logic line_o
);
    logic [16:0] sr_reg;
    logic [4:0] left_reg;

    // ==============================================================
    // shifter: msb first, one bit a clock, line low when idle
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sr_reg <= 17'h0_0000;
            left_reg <= 5'h00;
            line_o <= 1'h0;
        end
        else if (left_reg != 5'h00)
        begin
            line_o <= sr_reg[16];
            sr_reg <= sr_reg << 1;
            left_reg <= left_reg - 5'h01;
        end
        else if (go_i)
        begin
            line_o <= bits_i[16];
            sr_reg <= bits_i << 1;
            left_reg <= len_i - 5'h01;
        end
        else
        begin
            line_o <= 1'h0;
        end
    end
endmodule : plrh_link_model

// ### verif/plrh_top_asserts.sv
// port-level assertions for the link request handler
`timescale 1ns/100ps
`include "plrh_params.svh"

module plrh_top_asserts
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [1:0] INTERFACE_CONTROL_PAIR_I,
    input wire logic BUS_RESET_I,
    input wire logic ARB_WON_I,
    input wire logic STATUS_DONE_I,
    input wire logic IMMEDIATE_BUS_REQ_O,
    input wire logic ISOCHRONOUS_BUS_REQ_O,
    input wire logic PRIORITY_BUS_REQ_O,
    input wire logic FAIR_BUS_REQ_O,
    input wire logic GRANT_O,
    input wire logic STATUS_REG_REQ_O,
    input wire logic [3:0] STATUS_ADDR_O,
    input wire logic ACCEL_ACTIVE_O,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O
);
    logic arb_kind;
    logic in_rx;

    // ==============================================================
    // one domain, so one clocking and one disable
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    assign arb_kind = ISOCHRONOUS_BUS_REQ_O | PRIORITY_BUS_REQ_O |
        FAIR_BUS_REQ_O;
    assign in_rx = (INTERFACE_CONTROL_PAIR_I == `PLRH_CTL_RECEIVE);

    // ==============================================================
    // bus request lifetime
    chk_won_grant: assert property (
        ARB_WON_I && arb_kind && !BUS_RESET_I && !in_rx |=> GRANT_O)
        else $error("no grant after arbitration won");
    chk_grant_pulse: assert property (
        GRANT_O |=> !GRANT_O)
        else $error("grant longer than one cycle");
    chk_iso_hold: assert property (
        ISOCHRONOUS_BUS_REQ_O && !ARB_WON_I && !BUS_RESET_I
        |=> ISOCHRONOUS_BUS_REQ_O)
        else $error("isochronous request dropped early");
    chk_reset_clear: assert property (
        BUS_RESET_I |=> !arb_kind && !IMMEDIATE_BUS_REQ_O)
        else $error("bus request survived bus reset");
    chk_recv_clear: assert property (
        in_rx |=> !FAIR_BUS_REQ_O && !PRIORITY_BUS_REQ_O)
        else $error("fair or priority kept during receive");
    chk_one_pending: assert property (
        arb_kind && !ARB_WON_I && !BUS_RESET_I && !in_rx
        |=> $stable({ISOCHRONOUS_BUS_REQ_O, PRIORITY_BUS_REQ_O,
            FAIR_BUS_REQ_O}))
        else $error("pending bus request replaced");

    // ==============================================================
    // register read and software bus
    chk_read_hold: assert property (
        STATUS_REG_REQ_O && !STATUS_DONE_I
        |=> STATUS_REG_REQ_O && $stable(STATUS_ADDR_O))
        else $error("outstanding read lost or changed");
    chk_wb_ack_time: assert property (
        $rose(WB_CYC_I && WB_STB_I) |-> ##2 WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus ack not two cycles after request");

    // main scenarios seen
    cov_grant: cover property (GRANT_O);
    cov_read: cover property ($rose(STATUS_REG_REQ_O));
    cov_accel_off: cover property ($fell(ACCEL_ACTIVE_O));
endmodule : plrh_top_asserts

bind plrh_top plrh_top_asserts u_asserts (.*);

// ### verif/plrh_top_test.sv
// self-checking bench for the link request handler
`timescale 1ns/100ps
`include "plrh_params.svh"

`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            $display("unexpected %s: expected %h seen %h", nm, e, g); \
            n_mismatch++; \
        end \
    end

module plrh_top_test;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic lg = 1'h0;
    logic [4:0] ll = 5'h00;
    logic [16:0] lb = 17'h0_0000;
    logic line;
    logic [1:0] ctl = 2'h0;
    logic brst = 1'h0;
    logic won = 1'h0;
    logic sdone = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic imm, iso, pri, fair, gnt, txn, srq, acc, ack;
    logic [2:0] spd;
    logic [3:0] sadr;
    logic [7:0] sdat;
    int n_mismatch = 0;
    int checks_done = 0;

    // ==============================================================
    // 125 MHz clock, partner and design
    always #4 clk = ~clk;
    plrh_link_model lnk (.clk_i(clk), .arst_n_i(rst_n), .go_i(lg),
        .len_i(ll), .bits_i(lb), .line_o(line));
    plrh_top uut (.CLK_I(clk), .ARST_N_I(rst_n),
        .LINK_REQUEST_LINE_I(line), .INTERFACE_CONTROL_PAIR_I(ctl),
        .BUS_RESET_I(brst), .ARB_WON_I(won), .STATUS_DONE_I(sdone),
        .IMMEDIATE_BUS_REQ_O(imm), .ISOCHRONOUS_BUS_REQ_O(iso),
        .PRIORITY_BUS_REQ_O(pri), .FAIR_BUS_REQ_O(fair),
        .REQ_SPEED_O(spd), .GRANT_O(gnt), .TX_NULL_O(txn),
        .STATUS_REG_REQ_O(srq), .STATUS_ADDR_O(sadr),
        .STATUS_DATA_O(sdat), .ACCEL_ACTIVE_O(acc), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack));

    // ==============================================================
    // helpers: stream builder, link send, pulses, bus cycle
    function automatic logic [16:0] req(input plrh_pkg::plrh_req_t t,
        input logic [12:0] f);
        return {1'h1, t, f};
    endfunction : req

    task automatic end_of_test;
    begin
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask : end_of_test

    // waits out the stream length plus the three-edge answer delay
    task automatic send(input logic [4:0] n, input logic [16:0] b);
    begin
        @(posedge clk);
        lg <= 1'h1;
        ll <= n;
        lb <= b;
        @(posedge clk);
        lg <= 1'h0;
        repeat (n + 3) @(posedge clk);
        #1;
    end
    endtask : send

    task automatic hit(input logic b, input logic w, input logic d);
    begin
        @(posedge clk);
        brst <= b;
        won <= w;
        sdone <= d;
        @(posedge clk);
        brst <= 1'h0;
        won <= 1'h0;
        sdone <= 1'h0;
        #1;
    end
    endtask : hit

    task automatic rx(input int n);
    begin
        @(posedge clk);
        ctl <= `PLRH_CTL_RECEIVE;
        repeat (n) @(posedge clk);
        ctl <= `PLRH_CTL_IDLE;
    end
    endtask : rx

    // request held until ack is sampled; a stuck bus ends the run
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
    begin
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'h1 && n < 16);
        rq = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        if (n >= 16)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    endtask : wb

    task automatic want_grant;
        int n;
    begin
        n = 0;
        while (gnt !== 1'h1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("grant", 1'h1, gnt)
        if (gnt !== 1'h1)
            end_of_test();
    end
    endtask : want_grant

    // ==============================================================
    // scenarios
    task automatic t_regs;
    begin
        send(5'h11, req(plrh_pkg::PLRH_REQ_WRITE, {4'h3, 8'hA5, 1'h0}));
        wb(1'h0, 8'h4C, 32'h0000_0000);
        `CHK("reg3", 32'h0000_00A5, rq)
        wb(1'h1, 8'h5C, 32'h0000_003C);
        wb(1'h0, 8'h5C, 32'h0000_0000);
        `CHK("reg7", 32'h0000_003C, rq)
        wb(1'h0, 8'h80, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rq)
        send(5'h09, req(plrh_pkg::PLRH_REQ_READ, {4'h3, 9'h000}));
        `CHK("read pend", 1'h1, srq)
        `CHK("read addr", 4'h3, sadr)
        `CHK("read data", 8'hA5, sdat)
        send(5'h09, req(plrh_pkg::PLRH_REQ_READ, {4'h7, 9'h000}));
        `CHK("read kept", 4'h3, sadr)
        hit(1'h1, 1'h0, 1'h0);
        `CHK("read reset", 1'h1, srq)
        hit(1'h0, 1'h0, 1'h1);
        `CHK("read done", 1'h0, srq)
        $display("test regs done");
    end
    endtask : t_regs

    task automatic t_bus;
    begin
        send(5'h08, req(plrh_pkg::PLRH_REQ_RSVD, 13'h0000));
        `CHK("rsvd", 4'h0, {imm, iso, pri, fair})
        send(5'h08, req(plrh_pkg::PLRH_REQ_FAIR, {3'h2, 10'h000}));
        `CHK("fair", 1'h1, fair)
        `CHK("speed", 3'h2, spd)
        send(5'h08, req(plrh_pkg::PLRH_REQ_ISO, {3'h4, 10'h000}));
        `CHK("iso ignored", 1'h0, iso)
        rx(1);
        @(posedge clk);
        #1;
        `CHK("fair lost", 1'h0, fair)
        fork
            send(5'h08, req(plrh_pkg::PLRH_REQ_PRI, {3'h4, 10'h000}));
            rx(4);
        join
        `CHK("pri shift lost", 1'h0, pri)
        send(5'h08, req(plrh_pkg::PLRH_REQ_ISO, {3'h3, 10'h000}));
        `CHK("iso bad speed", 1'h1, iso)
        rx(2);
        send(5'h11, req(plrh_pkg::PLRH_REQ_WRITE, {4'h9, 8'h5A, 1'h0}));
        `CHK("iso kept", 1'h1, iso)
        wb(1'h0, 8'h64, 32'h0000_0000);
        `CHK("reg9", 32'h0000_005A, rq)
        hit(1'h0, 1'h1, 1'h0);
        want_grant();
        `CHK("null tx", 1'h1, txn)
        `CHK("iso won", 1'h0, iso)
        @(posedge clk);
        ctl <= `PLRH_CTL_RECEIVE;
        send(5'h07, req(plrh_pkg::PLRH_REQ_IMM, 13'h0000));
        `CHK("imm", 1'h1, imm)
        @(posedge clk);
        ctl <= `PLRH_CTL_IDLE;
        @(posedge clk);
        #1;
        want_grant();
        `CHK("real tx", 1'h0, txn)
        send(5'h08, req(plrh_pkg::PLRH_REQ_PRI, {3'h2, 10'h000}));
        hit(1'h1, 1'h0, 1'h0);
        `CHK("pri reset", 1'h0, pri)
        $display("test bus done");
    end
    endtask : t_bus

    task automatic t_accel;
    begin
        send(5'h11, req(plrh_pkg::PLRH_REQ_WRITE, {4'h5, 8'h02, 1'h0}));
        `CHK("accel on", 1'h1, acc)
        send(5'h06, req(plrh_pkg::PLRH_REQ_ACCEL, 13'h0000));
        `CHK("accel off", 1'h0, acc)
        hit(1'h1, 1'h0, 1'h0);
        `CHK("accel reset", 1'h1, acc)
        send(5'h06, req(plrh_pkg::PLRH_REQ_ACCEL, 13'h0000));
        send(5'h08, req(plrh_pkg::PLRH_REQ_ISO, 13'h0000));
        `CHK("accel iso", 1'h1, acc)
        hit(1'h1, 1'h0, 1'h0);
        send(5'h11, req(plrh_pkg::PLRH_REQ_WRITE, {4'h5, 8'h00, 1'h0}));
        send(5'h06, req(plrh_pkg::PLRH_REQ_ACCEL, 13'h1000));
        `CHK("accel gated", 1'h0, acc)
        $display("test accel done");
    end
    endtask : t_accel

    // ==============================================================
    // reset, then the scenarios in turn
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_bus();
        t_accel();
        end_of_test();
    end
endmodule : plrh_top_test
